// File: core/m0cb_config_bank.sv
// mode 0 regulator configuration bank: registers, decoding and on-pin edge handling
// Notes on behaviour
// - core buck code linear 0.5 V, 25 mV
// - core codes 41-62 clamp 1.5 V; 63 gives 1.8 V
// - core code resets to 1.00 V setting
// - on-edge select 0: falling edge returns to mode 0
// - on-edge select 1: falling edge changes nothing
// - offset bit adds 1.2 V to system buck
// - system buck code linear 1.5 V, clamps 2.1 V
// - system buck code resets to 1.8 V setting
// - always-on ldo code upper nibble, reset 1.8 V
// - core buck enable bit, resets on
// - system buck enable bit, resets on
// - always-on ldo code 1.7 V up, clamps 1.9 V
// - ldo enables in bits 1:0, reset on
module m0cb_config_bank #(
   parameter logic [5:0] CORE_CODE_DEF = m0cb_pkg::CORE_CODE_RST,
   parameter logic [4:0] SYS_CODE_DEF = m0cb_pkg::SYS_CODE_RST,
   parameter logic [3:0] AON_CODE_DEF = m0cb_pkg::AON_CODE_RST
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // register port from the serial bus engine
   input wire m0cb_pkg::m0cb_reg_req_t reg_req,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   // operating mode state
   input wire m0cb_pkg::m0cb_mode_t active_mode,
   input wire logic on_fall_valid,
   output logic return_to_m0,
   // regulator settings
   output m0cb_pkg::m0cb_reg_set_t reg_set
);
   // ****************************************
   // register storage
   // ****************************************
   logic [5:0] core_buck_volt_code_m0_r; // core buck code
   logic [4:0] sys_buck_volt_code_m0_r; // system buck code
   logic sys_buck_offset_sel_m0_r; // +1.2 V
   logic on_edge_sel_m0_r; // 1 = ignore falling edge
   logic rsvd_m0_r; // reserved, kept as written
   logic [3:0] aon_ldo_volt_code_m0_r;
   logic core_buck_on_m0_r;
   logic sys_buck_on_m0_r;
   logic aon_ldo_on_m0_r;
   logic sys_ldo_on_m0_r;
   logic [7:0] reg_rdata_r;
   logic reg_rvalid_r;
   logic return_to_m0_r;
   m0cb_pkg::m0cb_reg_set_t reg_set_r;

   // ****************************************
   // address decode
   // ****************************************
   wire logic sel_core = (reg_req.addr == m0cb_pkg::OFS_CORE_BUCK_CFG);
   wire logic sel_buck2 = (reg_req.addr == m0cb_pkg::OFS_BUCK2_ONEDGE_CFG);
   wire logic sel_ldo = (reg_req.addr == m0cb_pkg::OFS_LDO_EN_CFG);
   wire logic wr_core = reg_req.wr && sel_core;
   wire logic wr_buck2 = reg_req.wr && sel_buck2;
   wire logic wr_ldo = reg_req.wr && sel_ldo;
   wire logic [7:0] wd = reg_req.wdata;

   // read images; bits 7:6 of the core register belong to other logic and read zero
   wire logic [7:0] img_core = {2'b00, core_buck_volt_code_m0_r};
   wire logic [7:0] img_buck2 = {rsvd_m0_r, on_edge_sel_m0_r, sys_buck_offset_sel_m0_r,
                                 sys_buck_volt_code_m0_r};
   wire logic [7:0] img_ldo = {aon_ldo_volt_code_m0_r, core_buck_on_m0_r,
                               sys_buck_on_m0_r, aon_ldo_on_m0_r, sys_ldo_on_m0_r};
   wire logic [7:0] rd_mux = sel_core ? img_core :
                             sel_buck2 ? img_buck2 :
                             sel_ldo ? img_ldo : m0cb_pkg::RD_UNMAPPED;

   // ****************************************
   // voltage decoders
   // ****************************************
   logic [11:0] core_mv; // decoded core buck
   logic [11:0] sys_base_mv; // system buck before offset
   logic [11:0] aon_mv;

   m0cb_volt_decode #(
      .CODE_W(6),
      .BASE_MV(m0cb_pkg::CORE_BASE_MV),
      .STEP_MV(m0cb_pkg::STEP_MV),
      .MAX_CODE(m0cb_pkg::CORE_MAX_CODE),
      .HAS_FULL(1'b1),
      .FULL_MV(m0cb_pkg::CORE_FULL_MV)
   ) u_core_dec (
      .code(core_buck_volt_code_m0_r),
      .mv(core_mv)
   );

   m0cb_volt_decode #(
      .CODE_W(5),
      .BASE_MV(m0cb_pkg::SYS_BASE_MV),
      .STEP_MV(m0cb_pkg::STEP_MV),
      .MAX_CODE(m0cb_pkg::SYS_MAX_CODE),
      .HAS_FULL(1'b0),
      .FULL_MV(m0cb_pkg::SYS_BASE_MV)
   ) u_sys_dec (
      .code(sys_buck_volt_code_m0_r),
      .mv(sys_base_mv)
   );

   m0cb_volt_decode #(
      .CODE_W(4),
      .BASE_MV(m0cb_pkg::AON_BASE_MV),
      .STEP_MV(m0cb_pkg::STEP_MV),
      .MAX_CODE(m0cb_pkg::AON_MAX_CODE),
      .HAS_FULL(1'b0),
      .FULL_MV(m0cb_pkg::AON_BASE_MV)
   ) u_aon_dec (
      .code(aon_ldo_volt_code_m0_r),
      .mv(aon_mv)
   );

   // offset is added after the clamp, so the top system level is 3.3 V
   wire logic [11:0] sys_mv = sys_buck_offset_sel_m0_r ?
                              12'(sys_base_mv + m0cb_pkg::SYS_OFS_MV) : sys_base_mv;

   // ****************************************
   // mode gating and on-pin edge
   // ****************************************
   wire logic m0_active = (active_mode == m0cb_pkg::MODE_0);
   // already in mode 0 means no switch; select 1 means no switch at all
   wire logic ret_nxt = on_fall_valid && !on_edge_sel_m0_r && !m0_active;

   m0cb_pkg::m0cb_reg_set_t set_nxt;
   always_comb begin
      set_nxt = '0; // idle when another mode owns the regulators
      if (m0_active) begin
         set_nxt.valid = 1'b1;
         set_nxt.core_mv = core_mv;
         set_nxt.sys_mv = sys_mv;
         set_nxt.aon_mv = aon_mv;
         set_nxt.core_on = core_buck_on_m0_r;
         set_nxt.sys_on = sys_buck_on_m0_r;
         set_nxt.aon_on = aon_ldo_on_m0_r;
         set_nxt.sys_ldo_on = sys_ldo_on_m0_r;
      end
   end

   // ****************************************
   // core and system buck fields
   // ****************************************
   always_ff @(posedge clk) begin
      if (reset) begin
         core_buck_volt_code_m0_r <= CORE_CODE_DEF;
         sys_buck_volt_code_m0_r <= SYS_CODE_DEF;
         sys_buck_offset_sel_m0_r <= m0cb_pkg::BIT_CLR;
         on_edge_sel_m0_r <= m0cb_pkg::BIT_CLR;
         rsvd_m0_r <= m0cb_pkg::BIT_CLR;
      end else begin
         if (wr_core) begin
            core_buck_volt_code_m0_r <= wd[m0cb_pkg::CORE_CODE_LSB +: 6];
         end
         if (wr_buck2) begin
            sys_buck_volt_code_m0_r <= wd[m0cb_pkg::SYS_CODE_LSB +: 5];
            sys_buck_offset_sel_m0_r <= wd[m0cb_pkg::SYS_OFS_BIT];
            on_edge_sel_m0_r <= wd[m0cb_pkg::ON_CFG_BIT];
            rsvd_m0_r <= wd[m0cb_pkg::RSVD_BIT];
         end
      end
   end

   // ****************************************
   // ldo code and enable fields
   // ****************************************
   always_ff @(posedge clk) begin
      if (reset) begin
         aon_ldo_volt_code_m0_r <= AON_CODE_DEF;
         core_buck_on_m0_r <= m0cb_pkg::EN_RST;
         sys_buck_on_m0_r <= m0cb_pkg::EN_RST;
         aon_ldo_on_m0_r <= m0cb_pkg::EN_RST;
         sys_ldo_on_m0_r <= m0cb_pkg::EN_RST;
      end else if (wr_ldo) begin
         aon_ldo_volt_code_m0_r <= wd[m0cb_pkg::AON_CODE_LSB +: 4];
         core_buck_on_m0_r <= wd[m0cb_pkg::CORE_ON_BIT];
         sys_buck_on_m0_r <= wd[m0cb_pkg::SYS_ON_BIT];
         aon_ldo_on_m0_r <= wd[m0cb_pkg::AON_ON_BIT];
         sys_ldo_on_m0_r <= wd[m0cb_pkg::SYS_LDO_ON_BIT];
      end
   end

   // ****************************************
   // registered outputs
   // ****************************************
   // one register stage keeps regulator inputs glitch free; a write lands one edge after the edge that takes it
   always_ff @(posedge clk) begin
      if (reset) begin
         reg_rdata_r <= m0cb_pkg::RD_UNMAPPED;
         reg_rvalid_r <= 1'b0;
         return_to_m0_r <= 1'b0;
         reg_set_r <= '0;
      end else begin
         reg_rdata_r <= reg_req.rd ? rd_mux : reg_rdata_r;
         reg_rvalid_r <= reg_req.rd;
         return_to_m0_r <= ret_nxt;
         reg_set_r <= set_nxt;
      end
   end

   assign reg_rdata = reg_rdata_r;
   assign reg_rvalid = reg_rvalid_r;
   assign return_to_m0 = return_to_m0_r;
   assign reg_set = reg_set_r;

   // ****************************************
   // checks
   // ****************************************
   a_core_linear: assert property (
      @(posedge clk) disable iff (reset)
      (m0_active && core_buck_volt_code_m0_r <= m0cb_pkg::CORE_MAX_CODE)
      |=> (reg_set.core_mv == 12'(12'd500 + 12'd25 * 12'($past(core_buck_volt_code_m0_r)))))
      else $error("core buck linear level wrong");

   a_core_clamp_full: assert property (
      @(posedge clk) disable iff (reset)
      (m0_active && core_buck_volt_code_m0_r > m0cb_pkg::CORE_MAX_CODE)
      |=> (reg_set.core_mv == (($past(core_buck_volt_code_m0_r) == 6'h3f) ?
                               12'd1800 : 12'd1500)))
      else $error("core buck clamp or full level wrong");

   a_core_reset_code: assert property (
      @(posedge clk) reset |=> (core_buck_volt_code_m0_r == CORE_CODE_DEF)
      ##0 (sys_buck_volt_code_m0_r == SYS_CODE_DEF) ##0 (aon_ldo_volt_code_m0_r == AON_CODE_DEF))
      else $error("code default after reset wrong");

   a_on_edge_return: assert property (
      @(posedge clk) disable iff (reset)
      (on_fall_valid && !on_edge_sel_m0_r && !m0_active) |=> return_to_m0)
      else $error("falling edge did not request mode 0");

   a_on_edge_quiet: assert property (
      @(posedge clk) disable iff (reset)
      (on_edge_sel_m0_r || m0_active) |=> !return_to_m0)
      else $error("mode 0 requested when not allowed");

   a_sys_offset: assert property (
      @(posedge clk) disable iff (reset)
      (m0_active && sys_buck_offset_sel_m0_r) ##1 m0_active
      |-> (reg_set.sys_mv == 12'($past(sys_base_mv) + 12'd1200)))
      else $error("system buck offset not added");

   a_sys_clamp: assert property (
      @(posedge clk) disable iff (reset)
      (m0_active && !sys_buck_offset_sel_m0_r && sys_buck_volt_code_m0_r >= 5'h18)
      |=> (reg_set.sys_mv == 12'd2100))
      else $error("system buck clamp wrong");

   a_aon_level: assert property (
      @(posedge clk) disable iff (reset)
      (m0_active && aon_ldo_volt_code_m0_r >= 4'h8) |=> (reg_set.aon_mv == 12'd1900))
      else $error("always-on ldo clamp wrong");

   a_enables_reset: assert property (
      @(posedge clk) reset ##1 !reset && m0_active
      |=> (reg_set.core_on && reg_set.sys_on && reg_set.aon_on && reg_set.sys_ldo_on))
      else $error("enables not on after reset");

   a_mode_gate: assert property (
      @(posedge clk) disable iff (reset)
      !m0_active |=> (!reg_set.valid && reg_set.core_mv == 12'h000 && !reg_set.core_on))
      else $error("mode 0 settings driven outside mode 0");
endmodule

// File: core/m0cb_volt_decode.sv
// linear voltage code decoder with upper clamp and optional all-ones level
module m0cb_volt_decode #(
   parameter int CODE_W = 6,
   parameter logic [11:0] BASE_MV = 12'h000,
   parameter logic [11:0] STEP_MV = 12'h019,
   parameter logic [CODE_W-1:0] MAX_CODE = '1,
   parameter bit HAS_FULL = 1'b0,
   parameter logic [11:0] FULL_MV = 12'h000
) (
   // code in
   input wire logic [CODE_W-1:0] code,
   // millivolts out
   output logic [11:0] mv
);
   // ****************************************
   // decode
   // ****************************************
   wire logic is_full = HAS_FULL && (code == {CODE_W{1'b1}}); // dedicated level
   wire logic [CODE_W-1:0] eff_code = (code > MAX_CODE) ? MAX_CODE : code; // clamp
   wire logic [11:0] lin_mv = 12'(BASE_MV + STEP_MV * 12'(eff_code)); // linear step

   assign mv = is_full ? FULL_MV : lin_mv;
endmodule

// File: include/m0cb_pkg.sv
// package for the mode 0 regulator configuration bank: map, fields, defaults, voltages
package m0cb_pkg;
   // ****************************************
   // register map, byte offsets on the register port
   // ****************************************
   localparam logic [7:0] OFS_CORE_BUCK_CFG = 8'h22; // mode0_core_buck_config
   localparam logic [7:0] OFS_BUCK2_ONEDGE_CFG = 8'h23; // mode0_buck2_onedge_config
   localparam logic [7:0] OFS_LDO_EN_CFG = 8'h24; // mode0_ldo_and_enable_config
   localparam logic [7:0] RD_UNMAPPED = 8'h00; // answer to an unmapped read

   // ****************************************
   // field positions
   // ****************************************
   localparam int CORE_CODE_LSB = 0; // core buck code [5:0]
   localparam int SYS_CODE_LSB = 0; // system buck code [4:0]
   localparam int SYS_OFS_BIT = 5; // system buck +1.2 V offset
   localparam int ON_CFG_BIT = 6; // on-pin edge behaviour
   localparam int RSVD_BIT = 7; // reserved, plain storage
   localparam int AON_CODE_LSB = 4; // always-on ldo code [7:4]
   localparam int CORE_ON_BIT = 3;
   localparam int SYS_ON_BIT = 2;
   localparam int AON_ON_BIT = 1;
   localparam int SYS_LDO_ON_BIT = 0;

   // ****************************************
   // reset values (nonvolatile-programmable defaults)
   // ****************************************
   localparam logic [5:0] CORE_CODE_RST = 6'h14; // 1.000 V
   localparam logic [4:0] SYS_CODE_RST = 5'h0c; // 1.800 V
   localparam logic [3:0] AON_CODE_RST = 4'h4; // 1.800 V
   localparam logic EN_RST = 1'b1; // all regulators on
   localparam logic BIT_CLR = 1'b0; // offset, on-edge select, reserved

   // ****************************************
   // voltage mapping in millivolts
   // ****************************************
   localparam int MV_W = 12;
   localparam logic [11:0] CORE_BASE_MV = 12'h1f4; // 500 mV
   localparam logic [11:0] STEP_MV = 12'h019; // 25 mV
   localparam logic [5:0] CORE_MAX_CODE = 6'h28; // 1.500 V
   localparam logic [11:0] CORE_FULL_MV = 12'h708; // 1800 mV for all-ones
   localparam logic [11:0] SYS_BASE_MV = 12'h5dc; // 1500 mV
   localparam logic [4:0] SYS_MAX_CODE = 5'h18; // 2.100 V
   localparam logic [11:0] SYS_OFS_MV = 12'h4b0; // 1200 mV offset
   localparam logic [11:0] AON_BASE_MV = 12'h6a4; // 1700 mV
   localparam logic [3:0] AON_MAX_CODE = 4'h8; // 1.900 V

   // ****************************************
   // carriers
   // ****************************************
   typedef enum logic [1:0] {
      MODE_0 = 2'b00,
      MODE_1 = 2'b01,
      MODE_2 = 2'b10,
      MODE_3 = 2'b11
   } m0cb_mode_t;

   typedef struct packed {
      logic wr; // write strobe, one cycle
      logic rd; // read strobe, one cycle
      logic [7:0] addr;
      logic [7:0] wdata;
   } m0cb_reg_req_t;

   typedef struct packed {
      logic valid; // mode 0 settings are being driven
      logic [11:0] core_mv;
      logic [11:0] sys_mv;
      logic [11:0] aon_mv;
      logic core_on;
      logic sys_on;
      logic aon_on;
      logic sys_ldo_on;
   } m0cb_reg_set_t;
endpackage

// File: verification/m0cb_host.sv
// host-side model of the serial bus engine issuing single-byte register accesses
module m0cb_host (
   // clock
   input wire logic clk,
   // register port toward the bank
   output m0cb_pkg::m0cb_reg_req_t reg_req,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid
);
   timeunit 1ns;
   timeprecision 1ps;
   int gap = 0; // idle cycles before each access; nonzero makes a slow host
   initial reg_req = '0;

   // ****************************************
   // access tasks
   // ****************************************
   // one strobe cycle; released addr and data are inverted so stale values never match
   task automatic strobe(input logic w, input logic [7:0] a, input logic [7:0] d);
      repeat (gap) @(posedge clk);
      @(posedge clk);
      reg_req <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge clk);
      reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask

   // byte write, no answer expected
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      strobe(1'b1, a, d);
   endtask

   // byte read; answer sampled in the cycle after the taking edge
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
      strobe(1'b0, a, 8'h00);
      #1;
      v = reg_rvalid;
      d = reg_rdata;
   endtask
endmodule

// File: verification/tb.sv
// self-checking bench for the mode 0 regulator configuration bank
`define CHK(act, exp) begin n_checks++; if ((act) !== (exp)) begin n_mismatch++; \
   $display("MISMATCH t=%0t got %h exp %h", $time, act, exp); end end

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************
   // signals
   // ****************************************
   logic clk = 1'b0;
   logic reset = 1'b1;
   m0cb_pkg::m0cb_reg_req_t reg_req;
   logic [7:0] reg_rdata;
   logic reg_rvalid;
   m0cb_pkg::m0cb_mode_t active_mode = m0cb_pkg::MODE_0;
   logic on_fall_valid = 1'b0;
   logic return_to_m0;
   m0cb_pkg::m0cb_reg_set_t reg_set;
   int n_mismatch = 0;
   int n_checks = 0;
   logic [7:0] rd_d; // last read answer
   logic rd_v;
   logic [5:0] core_codes [7] = '{6'h00, 6'h01, 6'h27, 6'h28, 6'h29, 6'h3e, 6'h3f};
   logic [4:0] sys_codes [5] = '{5'h00, 5'h01, 5'h18, 5'h19, 5'h1f};

   // 200 MHz clock
   always #2.5 clk = ~clk;

   m0cb_config_bank dut (.clk(clk), .reset(reset), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .active_mode(active_mode), .on_fall_valid(on_fall_valid),
      .return_to_m0(return_to_m0), .reg_set(reg_set));
   m0cb_host host (.clk(clk), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

   // ****************************************
   // expected voltages in millivolts
   // ****************************************
   function automatic logic [11:0] core_exp(input logic [5:0] c);
      if (c == 6'h3f) return 12'h708; // all-ones is the fixed level, not the clamp
      return 12'h1f4 + 12'h019 * ((c > 6'h28) ? 12'h028 : {6'h00, c});
   endfunction
   function automatic logic [11:0] sys_exp(input logic [4:0] c, input logic o);
      return 12'h5dc + 12'h019 * ((c > 5'h18) ? 12'h018 : {7'h00, c}) + (o ? 12'h4b0 : 12'h000);
   endfunction
   function automatic logic [11:0] aon_exp(input logic [3:0] c);
      return 12'h6a4 + 12'h019 * ((c > 4'h8) ? 12'h008 : {8'h00, c});
   endfunction

   // ****************************************
   // helper tasks
   // ****************************************
   // let a write or mode change reach the registered outputs
   task automatic settle();
      repeat (2) @(posedge clk);
      #1;
   endtask
   // read and compare one register image
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      host.read_reg(a, rd_d, rd_v);
      `CHK(rd_v, 1'b1)
      `CHK(rd_d, e)
   endtask
   // on-pin edge in a given mode, then look for the return pulse and its end
   task automatic pulse_on(input m0cb_pkg::m0cb_mode_t m, input logic e);
      @(posedge clk);
      active_mode <= m;
      on_fall_valid <= 1'b1;
      @(posedge clk);
      on_fall_valid <= 1'b0;
      #1;
      `CHK(return_to_m0, e)
      @(posedge clk);
      #1;
      `CHK(return_to_m0, 1'b0)
   endtask

   // verdict, reached from the main sequence or the watchdog
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // watchdog: the sequence needs well under 2000 cycles
   initial begin
      #(4000 * 5);
      n_mismatch++;
      end_sim();
   end

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      settle();
      // reset images and decoded defaults
      rd_chk(8'h22, 8'h14);
      rd_chk(8'h23, 8'h0c);
      rd_chk(8'h24, 8'h4f);
      `CHK(reg_set, {1'b1, 12'h3e8, 12'h708, 12'h708, 4'hf})
      // unmapped places: write dropped, read gives zero; slow host here
      host.gap = 3;
      host.write_reg(8'h21, 8'h3f);
      rd_chk(8'h25, 8'h00);
      rd_chk(8'h22, 8'h14);
      host.gap = 0;
      // core buck codes around the clamp and the all-ones level
      foreach (core_codes[i]) begin
         host.write_reg(8'h22, {2'b11, core_codes[i]});
         settle();
         `CHK(reg_set.core_mv, core_exp(core_codes[i]))
         rd_chk(8'h22, {2'b00, core_codes[i]});
      end
      // system buck codes with and without offset, reserved bit stored
      for (int o = 0; o < 2; o++) begin
         foreach (sys_codes[i]) begin
            host.write_reg(8'h23, {1'b1, 1'b0, o[0], sys_codes[i]});
            settle();
            `CHK(reg_set.sys_mv, sys_exp(sys_codes[i], o[0]))
            rd_chk(8'h23, {1'b1, 1'b0, o[0], sys_codes[i]});
         end
      end
      // always-on ldo codes, enables toggled through every pattern edge
      for (int c = 0; c < 16; c++) begin
         host.write_reg(8'h24, {c[3:0], ~c[3:0]});
         settle();
         `CHK(reg_set.aon_mv, aon_exp(c[3:0]))
         // low struct bits are core_on, sys_on, aon_on, sys_ldo_on, msb first
         `CHK(reg_set[3:0], ~c[3:0])
      end
      // settings withheld outside mode 0, applied on return
      @(posedge clk);
      active_mode <= m0cb_pkg::MODE_1;
      settle();
      `CHK(reg_set, '0)
      host.write_reg(8'h22, 8'h00);
      settle();
      `CHK(reg_set, '0)
      @(posedge clk);
      active_mode <= m0cb_pkg::MODE_0;
      settle();
      `CHK(reg_set.valid, 1'b1)
      `CHK(reg_set.core_mv, 12'h1f4)
      // on-pin edge with select clear, then set
      pulse_on(m0cb_pkg::MODE_1, 1'b1);
      pulse_on(m0cb_pkg::MODE_3, 1'b1);
      pulse_on(m0cb_pkg::MODE_0, 1'b0);
      host.write_reg(8'h23, 8'h4c);
      pulse_on(m0cb_pkg::MODE_2, 1'b0);
      pulse_on(m0cb_pkg::MODE_0, 1'b0);
      rd_chk(8'h23, 8'h4c);
      end_sim();
   end
endmodule
